// ---- verilog/mon_snapshot_pkg.sv ----
// Purpose: shared constants for the monitoring snapshot buffer
// Assumes: one crossing per clock enable cycle
// Notes: header word layout and counter widths live here
package mon_snapshot_pkg;
    localparam int ELEMENTS = 4;
    localparam int SAMPLE_W = 16;
    localparam int DEPTH_LOG2 = 4;
    localparam int FIFO_LOG2 = 7;
    localparam int XID_W = 12;
    localparam int CNT_W = 16;
    localparam int WIN_W = 4;
    localparam logic [WIN_W-1:0] WIN_MIN = 4'h5;
    localparam logic [WIN_W-1:0] WIN_MAX = 4'ha;
    localparam logic [3:0] HDR_TAG = 4'ha;
    // request source bits
    localparam int SRC_ACCEPT = 0;
    localparam int SRC_RANDOM = 1;
    localparam int SRC_SEGMENT = 2;
    localparam int SRC_ANGLE = 3;
    localparam int SRC_PEER = 4;
    localparam int SRC_PAD = 5;
    localparam int SRC_N = 6;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_COPY = 2'b01,
        ST_HEAD = 2'b11,
        ST_SEND = 2'b10
    } snap_state_e;
endpackage : mon_snapshot_pkg

// ---- verilog/pin_sync3.sv ----
// Purpose: three-stage synchroniser with agreement check
// Assumes: input is asynchronous to mclk
// Notes: first stage is read only by the second
`timescale 1ns/1ns
module pin_sync3 (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic pin,
    output logic level
);
    logic s1;
    logic s2;
    logic s3;
    always_ff @(posedge mclk) begin
        if (rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level <= 1'b0;
        end else if (ce) begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule : pin_sync3

// ---- verilog/monitoring_snapshot_buffer.sv ----
// Purpose: per-element circular capture, snapshot FIFO and packet output
// Assumes: ce marks one crossing per cycle; link consumer gives link_ready
// Notes: one request handled at a time; requests while busy are counted
// Notes on behaviour
// - hold samples until a send request arrives
// - accept, random, segment, angle-fail selections
// - capture all inputs plus outputs over window
// - circular buffer written every crossing, except while frozen from the copy until the last word is sent
// - one circular buffer per readout element
// - extract contiguous crossing range, five to ten
// - extracted samples go into second-stage FIFO
// - send header and data after request complete
// - per-fiber raw enable, forward non-zero packets
// - coincidence record carries hits, debug, fit
// - exchange send request with peer on line
// - peer request also triggers own capture
// - pad unit request accepted too
// - counters for segments, link errors, volume
// - output over shared serial sub-link
`timescale 1ns/1ns
module monitoring_snapshot_buffer
    import mon_snapshot_pkg::*;
#(
    parameter int N_EL = ELEMENTS,
    parameter int W = SAMPLE_W,
    parameter int DL = DEPTH_LOG2,
    parameter int FL = FIFO_LOG2
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [N_EL*W-1:0] element_sample,
    input wire logic [W-1:0] segment_out,
    input wire logic [W-1:0] coinc_record,
    input wire logic [N_EL-1:0] fiber_enable,
    input wire logic [XID_W-1:0] crossing_identifier,
    input wire logic first_level_accept,
    input wire logic random_pick,
    input wire logic segment_found,
    input wire logic angle_fail,
    input wire logic [SRC_N-1:0] select_enable,
    input wire logic [WIN_W-1:0] window_len,
    input wire logic [WIN_W-1:0] window_pre,
    input wire logic peer_request_pin,
    input wire logic pad_request_pin,
    input wire logic [7:0] seg_accepted,
    input wire logic [7:0] seg_rejected,
    input wire logic link_error,
    input wire logic link_ready,
    output logic peer_request_out,
    output logic [W-1:0] link_data,
    output logic link_valid,
    output logic link_sof,
    output logic busy,
    output logic [CNT_W-1:0] count_accepted,
    output logic [CNT_W-1:0] count_rejected,
    output logic [CNT_W-1:0] count_link_err,
    output logic [CNT_W-1:0] count_words,
    output logic [CNT_W-1:0] count_dropped
);
    localparam int SLOTS = N_EL + 2;
    localparam int SEL_W = $clog2(SLOTS + 1);

    logic peer_req;
    logic pad_req;
    pin_sync3 u_peer (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .pin(peer_request_pin),
        .level(peer_req)
    );
    pin_sync3 u_pad (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .pin(pad_request_pin),
        .level(pad_req)
    );

    // circular store: one ring per element plus segment and coincidence rings
    logic [W-1:0] ring [SLOTS][2**DL];
    logic [DL-1:0] wr_ptr;
    logic freeze;
    logic [SLOTS*W-1:0] slot_in;
    assign slot_in = {coinc_record, segment_out, element_sample};

    genvar g;
    generate
        for (g = 0; g < SLOTS; g++) begin : g_ring
            always_ff @(posedge mclk) begin
                if (ce && !freeze) begin
                    ring[g][wr_ptr] <= slot_in[g*W +: W];
                end
            end
        end
    endgenerate

    // request sources
    logic [SRC_N-1:0] src;
    assign src = {pad_req, peer_req, angle_fail, segment_found, random_pick,
                  first_level_accept};
    wire local_req = |(src[SRC_ANGLE:SRC_ACCEPT] & select_enable[SRC_ANGLE:SRC_ACCEPT]);
    wire peer_hit = src[SRC_PEER] & select_enable[SRC_PEER];
    wire pad_hit = src[SRC_PAD] & select_enable[SRC_PAD];
    wire request = local_req | peer_hit | pad_hit;

    // clamp window into documented range
    function automatic logic [WIN_W-1:0] clamp_win(input logic [WIN_W-1:0] v);
        if (v < WIN_MIN) begin
            return WIN_MIN;
        end
        if (v > WIN_MAX) begin
            return WIN_MAX;
        end
        return v;
    endfunction : clamp_win
    wire [WIN_W-1:0] win = clamp_win(window_len);

    snap_state_e state;
    snap_state_e next_state;
    logic [WIN_W-1:0] post_left;
    logic [DL-1:0] rd_ptr;
    logic [WIN_W-1:0] xc;
    logic [SEL_W-1:0] el;
    logic [XID_W-1:0] snap_xid;
    logic [FL:0] f_wr;
    logic [FL:0] f_rd;
    logic [W-1:0] fifo [2**FL];
    logic [WIN_W-1:0] win_q;

    // write pointer stops under freeze, so the window start stays put
    assign rd_ptr = wr_ptr - DL'(win_q);
    assign freeze = (state != ST_IDLE) && (post_left == '0);
    assign busy = (state != ST_IDLE);

    // raw element slots respect fiber enable and zero suppression
    wire [W-1:0] cur_word = ring[el][rd_ptr + DL'(xc)];
    wire slot_is_raw = (el < SEL_W'(N_EL));
    wire raw_en = slot_is_raw ? fiber_enable[el[$clog2(N_EL)-1:0]] : 1'b1;
    wire keep_word = raw_en && (!slot_is_raw || cur_word != '0);
    wire fifo_full = (f_wr[FL] != f_rd[FL]) && (f_wr[FL-1:0] == f_rd[FL-1:0]);
    wire fifo_empty = (f_wr == f_rd);
    wire copy_step = (state == ST_COPY) && freeze && !fifo_full;
    wire last_xc = (xc == win_q - 4'h1);
    wire last_el = (el == SEL_W'(SLOTS - 1));
    wire copy_done = copy_step && last_xc && last_el;
    wire head_take = (state == ST_HEAD) && link_ready;
    wire send_take = (state == ST_SEND) && link_ready && !fifo_empty;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (ce && request) begin
                    next_state = ST_COPY;
                end
            end
            ST_COPY: begin
                if (copy_done) begin
                    next_state = ST_HEAD;
                end
            end
            ST_HEAD: begin
                if (head_take) begin
                    next_state = ST_SEND;
                end
            end
            ST_SEND: begin
                if (send_take && (f_rd + 1'b1 == f_wr)) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= ST_IDLE;
            wr_ptr <= '0;
            post_left <= '0;
            xc <= '0;
            el <= '0;
            snap_xid <= '0;
            win_q <= WIN_MIN;
            peer_request_out <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            peer_request_out <= local_req | pad_hit;
            if (!freeze) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (state == ST_IDLE && request) begin
                // keep writing for the crossings after the selected one
                win_q <= win;
                post_left <= (win > window_pre) ? win - window_pre - 4'h1 : '0;
                snap_xid <= crossing_identifier;
                xc <= '0;
                el <= '0;
            end else if (post_left != '0) begin
                post_left <= post_left - 4'h1;
            end
            if (copy_step) begin
                if (last_el) begin
                    el <= '0;
                    xc <= xc + 4'h1;
                end else begin
                    el <= el + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            f_wr <= '0;
        end else if (ce && copy_step && keep_word) begin
            fifo[f_wr[FL-1:0]] <= cur_word;
            f_wr <= f_wr + 1'b1;
        end
    end

    // each word is loaded before it is offered, so data holds under stall
    wire [FL:0] f_rd_next = f_rd + 1'b1;
    always_ff @(posedge mclk) begin
        if (rst) begin
            f_rd <= '0;
            link_data <= '0;
            link_sof <= 1'b0;
        end else if (ce) begin
            if (copy_done) begin
                link_data <= W'({HDR_TAG, snap_xid});
                link_sof <= 1'b1;
            end else if (head_take) begin
                link_data <= fifo[f_rd[FL-1:0]];
                link_sof <= 1'b0;
            end else if (send_take) begin
                link_data <= fifo[f_rd_next[FL-1:0]];
                f_rd <= f_rd_next;
            end
        end
    end
    assign link_valid = (state == ST_HEAD) || (state == ST_SEND && !fifo_empty);

    // statistics counters
    always_ff @(posedge mclk) begin
        if (rst) begin
            count_accepted <= '0;
            count_rejected <= '0;
            count_link_err <= '0;
            count_words <= '0;
            count_dropped <= '0;
        end else if (ce) begin
            count_accepted <= count_accepted + CNT_W'(seg_accepted);
            count_rejected <= count_rejected + CNT_W'(seg_rejected);
            if (link_error) begin
                count_link_err <= count_link_err + 1'b1;
            end
            if (head_take || send_take) begin
                count_words <= count_words + 1'b1;
            end
            if (busy && request) begin
                count_dropped <= count_dropped + 1'b1;
            end
        end
    end
endmodule : monitoring_snapshot_buffer

// ---- tb/mon_snapshot_properties.sv ----
// Purpose: port checks for the snapshot buffer
// Assumes: one mclk domain, synchronous rst
// Notes: cap_xid keeps the crossing seen at the take edge
`timescale 1ns/1ns
module mon_snapshot_checker
    import mon_snapshot_pkg::*;
#(
    parameter int W = SAMPLE_W
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [XID_W-1:0] crossing_identifier,
    input wire logic first_level_accept,
    input wire logic random_pick,
    input wire logic segment_found,
    input wire logic angle_fail,
    input wire logic [SRC_N-1:0] select_enable,
    input wire logic link_error,
    input wire logic link_ready,
    input wire logic peer_request_out,
    input wire logic [W-1:0] link_data,
    input wire logic link_valid,
    input wire logic link_sof,
    input wire logic busy,
    input wire logic [CNT_W-1:0] count_link_err,
    input wire logic [CNT_W-1:0] count_dropped
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire logic [3:0] picks = {angle_fail, segment_found, random_pick, first_level_accept};
    wire logic local_req = ce & |(picks & select_enable[3:0]);
    logic [XID_W-1:0] cap_xid;
    // frozen while busy, so the header sees the taken crossing
    always_ff @(posedge mclk) begin
        if (!busy) begin
            cap_xid <= crossing_identifier;
        end
    end
    sequence s_take;
        !busy && local_req;
    endsequence
    sequence s_header;
        link_valid && link_sof;
    endsequence
    take_busy_a: assert property (s_take |=> busy)
        else $error("request not taken");
    hdr_word_a: assert property (s_header |-> link_data[W-1:W-4] == HDR_TAG
        && link_data[XID_W-1:0] == cap_xid) else $error("bad header word");
    valid_busy_a: assert property (link_valid |-> busy)
        else $error("word sent while idle");
    data_hold_a: assert property (link_valid && !link_ready |=>
        link_valid && $stable(link_data)) else $error("word lost under stall");
    sof_valid_a: assert property (link_sof |-> link_valid)
        else $error("header flag without word");
    err_count_a: assert property (ce && link_error |=>
        count_link_err == $past(count_link_err) + 16'h1) else $error("link error missed");
    peer_out_a: assert property (local_req |=> peer_request_out)
        else $error("peer not told");
    drop_count_a: assert property (busy && local_req |=>
        count_dropped == $past(count_dropped) + 16'h1) else $error("drop not counted");
endmodule : mon_snapshot_checker

// ---- tb/link_sink.sv ----
// Purpose: readout concentrator stand-in
// Assumes: the block samples link_ready as a level
// Notes: stall gives ready one cycle in four
`timescale 1ns/1ns
module link_sink (
    input wire logic mclk,
    input wire logic rst,
    input wire logic stall,
    input wire logic link_valid,
    output logic link_ready,
    output logic [15:0] n_acc
);
    logic [1:0] ph;
    always_ff @(posedge mclk) begin
        if (rst) begin
            ph <= 2'h0;
            n_acc <= 16'h0;
        end else begin
            ph <= ph + 2'h1;
            n_acc <= n_acc + 16'(link_valid & link_ready);
        end
    end
    assign link_ready = !stall || ph == 2'h0;
endmodule : link_sink

// ---- tb/monitoring_snapshot_buffer_tb_top.sv ----
// Purpose: directed bench for the snapshot buffer
// Assumes: ce high, window_pre fixed at 2
// Notes: word counts include the header word
`timescale 1ns/1ns
module monitoring_snapshot_buffer_tb_top
    import mon_snapshot_pkg::*;
;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [XID_W-1:0] xid = 12'h0;
    logic [3:0] pick = 4'h0;
    logic [SRC_N-1:0] sel = 6'h1;
    logic [3:0] fib = 4'hf;
    logic [WIN_W-1:0] wlen = 4'h5;
    logic [7:0] acc = 8'h0;
    logic peer_pin = 1'b0, pad_pin = 1'b0, lerr = 1'b0, stall = 1'b0;
    logic ready, peer_out, valid, sof, busy;
    logic [15:0] data, c_acc, c_rej, c_err, c_words, c_drop, n_acc;
    int miscompares = 0;
    int n_tests = 0;
    int peer_hits = 0;
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk) xid <= xid + 12'h1;
    always @(posedge mclk) peer_hits <= peer_hits + int'(peer_out === 1'b1);
    monitoring_snapshot_buffer DUT (.mclk(mclk), .rst(rst), .ce(1'b1),
        .element_sample({ELEMENTS{4'h1, xid}}), .segment_out({4'h2, xid}),
        .coinc_record({4'h3, xid}), .fiber_enable(fib), .crossing_identifier(xid),
        .first_level_accept(pick[0]), .random_pick(pick[1]), .segment_found(pick[2]),
        .angle_fail(pick[3]), .select_enable(sel), .window_len(wlen), .window_pre(4'h2),
        .peer_request_pin(peer_pin), .pad_request_pin(pad_pin), .seg_accepted(acc),
        .seg_rejected(acc), .link_error(lerr), .link_ready(ready),
        .peer_request_out(peer_out), .link_data(data), .link_valid(valid),
        .link_sof(sof), .busy(busy), .count_accepted(c_acc), .count_rejected(c_rej),
        .count_link_err(c_err), .count_words(c_words), .count_dropped(c_drop));
    link_sink u_sink (.mclk(mclk), .rst(rst), .stall(stall), .link_valid(valid),
        .link_ready(ready), .n_acc(n_acc));
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task test_done;
        if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    task wait_busy(input logic lvl, input int lim);
        for (int i = 0; i < lim && busy !== lvl; i++) @(negedge mclk);
        if (busy !== lvl) begin
            miscompares++;
            test_done();
        end
    endtask : wait_busy
    task req(input int s, output int words);
        logic [15:0] n0, c0;
        n0 = n_acc;
        c0 = c_words;
        @(posedge mclk);
        sel <= 6'h1 << s;
        pick[s] <= 1'b1;
        @(posedge mclk);
        pick[s] <= 1'b0;
        wait_busy(1'b1, 4);
        wait_busy(1'b0, 3000);
        words = n_acc - n0;
        check("count_words", c_words - c0, words);
    endtask : req
    task t_sources;
        int w;
        check("idle", {busy, valid, sof, peer_out}, 0);
        check("idle_cnt", {c_words, c_drop}, 0);
        // let the rings fill before the first window is read
        repeat (2**DEPTH_LOG2) @(negedge mclk);
        for (int s = 0; s < 4; s++) begin
            req(s, w);
            check("words", w, 1 + 5 * (ELEMENTS + 2));
        end
        @(posedge mclk);
        sel <= 6'h3e;
        pick[0] <= 1'b1;
        @(posedge mclk);
        pick[0] <= 1'b0;
        repeat (3) @(negedge mclk);
        check("masked", busy, 1'b0);
    endtask : t_sources
    task t_window;
        int w;
        @(posedge mclk);
        wlen <= 4'hf;
        stall <= 1'b1;
        req(0, w);
        check("clamp_hi", w, 1 + 10 * (ELEMENTS + 2));
        @(posedge mclk);
        wlen <= 4'h7;
        fib <= 4'h5;
        req(0, w);
        check("fibers", w, 1 + 7 * 4);
        @(posedge mclk);
        wlen <= 4'h2;
        fib <= 4'hf;
        stall <= 1'b0;
        req(0, w);
        check("clamp_lo", w, 1 + 5 * (ELEMENTS + 2));
    endtask : t_window
    task t_drop;
        logic [15:0] d0;
        d0 = c_drop;
        @(posedge mclk);
        pick[0] <= 1'b1;
        @(posedge mclk);
        pick[0] <= 1'b0;
        @(posedge mclk);
        pick[0] <= 1'b1;
        @(posedge mclk);
        pick[0] <= 1'b0;
        wait_busy(1'b0, 3000);
        check("dropped", c_drop, d0 + 16'h1);
    endtask : t_drop
    task t_pins;
        int h0, hp;
        hp = peer_hits;
        @(posedge mclk);
        sel <= 6'h30;
        peer_pin <= 1'b1;
        wait_busy(1'b1, 12);
        @(posedge mclk);
        peer_pin <= 1'b0;
        wait_busy(1'b0, 3000);
        h0 = peer_hits;
        check("peer_no_echo", h0 == hp, 1'b1);
        @(posedge mclk);
        pad_pin <= 1'b1;
        wait_busy(1'b1, 12);
        @(posedge mclk);
        pad_pin <= 1'b0;
        wait_busy(1'b0, 3000);
        check("pad_echo", peer_hits > h0, 1'b1);
    endtask : t_pins
    task t_counters;
        logic [15:0] a0, r0, e0;
        a0 = c_acc;
        r0 = c_rej;
        e0 = c_err;
        @(posedge mclk);
        acc <= 8'h3;
        lerr <= 1'b1;
        @(posedge mclk);
        lerr <= 1'b0;
        @(posedge mclk);
        lerr <= 1'b1;
        @(posedge mclk);
        lerr <= 1'b0;
        @(posedge mclk);
        acc <= 8'h0;
        @(negedge mclk);
        check("accepted", c_acc, a0 + 16'hc);
        check("rejected", c_rej, r0 + 16'hc);
        check("link_err", c_err, e0 + 16'h2);
    endtask : t_counters
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        t_sources();
        t_window();
        t_drop();
        t_pins();
        t_counters();
        test_done();
    end
endmodule : monitoring_snapshot_buffer_tb_top
bind monitoring_snapshot_buffer mon_snapshot_checker #(.W(W)) u_chk (.mclk, .rst, .ce,
    .crossing_identifier, .first_level_accept, .random_pick, .segment_found, .angle_fail,
    .select_enable, .link_error, .link_ready, .peer_request_out, .link_data, .link_valid,
    .link_sof, .busy, .count_link_err, .count_dropped);
